// file: hdl/gpt_gate_stage.sv
/*
  Gate conditioning: optional inversion of the comparator output and
  optional two-flop resynchronisation to ref_clk.
  Assumes the comparator output is asynchronous to ref_clk.
*/
`default_nettype none
module gpt_gate_stage
  import gpt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic compOut,
  input wire logic invert,
  input wire logic sync,
  output logic timerGate
);
  logic syncA;
  logic syncB;
  logic next_syncA;
  logic next_syncB;
  logic polarized;

  // Inversion ahead of the gate
  assign polarized = compOut ^ invert;

  // Synchroniser next values; first flop feeds only the second
  always_comb
  begin
    next_syncA = polarized;
    next_syncB = syncA;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      syncA <= GPT_GATE_IDLE;
      syncB <= GPT_GATE_IDLE;
    end
    else
    begin
      syncA <= next_syncA;
      syncB <= next_syncB;
    end
  end

  // Bypass only safe when an external falling-edge flop retimes it
  assign timerGate = sync ? syncB : polarized;
endmodule
`default_nettype wire

// file: hdl/gpt_timer.sv
/*
  Gated pulse width timer: counts ref_clk cycles while the conditioned
  comparator output (timer gate input) is low, holds otherwise.
  Assumes control pins are synchronous to ref_clk and that, with the
  sync bit clear, the comparator is retimed externally.
  Clear wins over load, and both win over counting; a pulse that ends
  in the same cycle as a clear or load still raises done, so software
  never misses the end of a window it was racing.
  After done rises the count stays frozen while the gate is high; a
  second low phase before software clears adds onto the old result.
  The counter wraps at the top of its range with no overflow flag, so
  pulses longer than the range alias.
*/
// Function
// - Timer increments each clock only while the timer gate input is low.
// - Gate high holds the count unchanged.
// - Count equals cycles from falling to following rising comparator edge.
// - Invert bit flips comparator output, measuring rising-to-falling interval.
// - Sync bit retimes comparator output to the timer clock before gating.
`default_nettype none
module gpt_timer
  import gpt_pkg::*;
#(
  parameter int COUNT_W = GPT_COUNT_W
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic compOut,
  input wire gpt_ctrl_t ctrl,
  input wire logic [COUNT_W-1:0] preset,
  output logic [COUNT_W-1:0] count,
  output gpt_stat_t stat
);
  logic timerGate;
  logic [COUNT_W-1:0] next_count;
  gpt_stat_t next_stat;
  gpt_state_t state;
  gpt_state_t next_state;
  logic advance;
  logic windowEnd;

  // Wraps at the top of the range; no overflow flag is kept
  function automatic logic [COUNT_W-1:0] bump(input logic [COUNT_W-1:0] value);
    return value + COUNT_W'(1);
  endfunction

  gpt_gate_stage gpt_gate_stage_inst (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .compOut(compOut),
    .invert(ctrl.invert),
    .sync(ctrl.sync),
    .timerGate(timerGate)
  );

  // Gate acts as count enable; low means count
  assign advance = ctrl.enable && !timerGate;

  // Pulse end as the phase logic sees it
  // Shared by the done flag and by clear/load so neither loses it
  assign windowEnd = (state == GPT_MEASURE) && !advance;

  // Counter and phase next values; clear/load beat counting
  always_comb
  begin
    next_count = count;
    next_state = state;
    next_stat = stat;
    next_stat.gateLow = !timerGate;
    next_stat.counting = 1'b0;
    if (ctrl.clear)
    begin
      // Set beats clear: a pulse ending now still reports done
      next_count = COUNT_W'(GPT_COUNT_RST);
      next_state = GPT_IDLE;
      next_stat.done = windowEnd;
    end
    else if (ctrl.load)
    begin
      next_count = preset;
      next_state = GPT_IDLE;
      next_stat.done = windowEnd;  // Same set-wins rule as clear
    end
    else
    begin
      if (advance)
      begin
        next_count = bump(count);
        next_stat.counting = 1'b1;
      end
      unique case (state)
        GPT_IDLE:
        begin
          if (advance)
          begin
            next_state = GPT_MEASURE;
          end
        end
        GPT_MEASURE:
        begin
          // Gate rose: pulse ended, count holds while the gate stays high
          if (!advance)
          begin
            next_state = GPT_DONE;
            next_stat.done = 1'b1;
          end
        end
        GPT_DONE:
        begin
          next_stat.done = 1'b1;
        end
      endcase
    end
  end

  // Done phase keeps counting if gate goes low again; software must clear
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      count <= COUNT_W'(GPT_COUNT_RST);
      state <= GPT_IDLE;
      stat <= '0;
    end
    else
    begin
      count <= next_count;
      state <= next_state;
      stat <= next_stat;
    end
  end

  // Assertions
  sequence s_gateLowEn;
    ctrl.enable && !timerGate && !ctrl.clear && !ctrl.load;
  endsequence

  sequence s_gateHighHold;
    (timerGate || !ctrl.enable) && !ctrl.clear && !ctrl.load;
  endsequence

  // First counting cycle of a fresh window
  sequence s_pulseStart;
    state == GPT_IDLE && advance && !ctrl.clear && !ctrl.load;
  endsequence

  a_count_advances: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_gateLowEn |=> count == $past(count) + COUNT_W'(1))
    else $error("count did not advance with gate low");

  a_count_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_gateHighHold |=> $stable(count))
    else $error("count moved with gate high");

  a_invert_path: assert property (@(posedge ref_clk) disable iff (!rstn)
    !ctrl.sync |-> timerGate == (compOut ^ ctrl.invert))
    else $error("gate polarity wrong");

  a_sync_delay: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrl.sync && $past(ctrl.sync) && $past(ctrl.sync, 2)
      |-> timerGate == $past(compOut ^ ctrl.invert, GPT_SYNC_STAGES))
    else $error("sync path not two cycles");

  a_done_sets: assert property (@(posedge ref_clk) disable iff (!rstn)
    state == GPT_MEASURE && !advance && !ctrl.clear && !ctrl.load |=> stat.done)
    else $error("done not set at pulse end");

  a_done_sticky: assert property (@(posedge ref_clk) disable iff (!rstn)
    stat.done && !ctrl.clear && !ctrl.load |=> stat.done)
    else $error("done dropped without clear");

  a_clear_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrl.clear |=> count == GPT_COUNT_RST && stat.done == $past(windowEnd))
    else $error("clear failed");

  a_load_preset: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrl.load && !ctrl.clear |=> count == $past(preset) && stat.done == $past(windowEnd))
    else $error("load failed");

  a_clear_beats_load: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrl.clear && ctrl.load |=> count == GPT_COUNT_RST)
    else $error("load overrode clear");

  a_rearm_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrl.clear || ctrl.load |=> state == GPT_IDLE)
    else $error("phase not rearmed");

  // Frozen result: nothing moves while the gate stays high after a pulse
  a_done_freeze: assert property (@(posedge ref_clk) disable iff (!rstn)
    state == GPT_DONE && timerGate && !ctrl.clear && !ctrl.load
      |=> $stable(count) && stat.done)
    else $error("result moved after pulse end");

  // The gateLow flag mirrors the gate every cycle, enable or not
  a_gate_flag_low: assert property (@(posedge ref_clk) disable iff (!rstn)
    !timerGate |=> stat.gateLow)
    else $error("gate low flag missing");

  a_gate_flag_high: assert property (@(posedge ref_clk) disable iff (!rstn)
    timerGate |=> !stat.gateLow)
    else $error("gate low flag with gate high");

  a_counting_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_gateLowEn |=> stat.counting)
    else $error("counting flag missing");

  // Enable low refuses counting whatever the gate does
  a_enable_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    !ctrl.enable && !ctrl.clear && !ctrl.load |=> $stable(count) && !stat.counting)
    else $error("count moved with timer off");

  // One window: open, two more low cycles, close; three counts and done
  a_window_open: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_pulseStart |=> state == GPT_MEASURE)
    else $error("window did not open");

  a_window_three: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_pulseStart ##1 s_gateLowEn [*2] ##1 s_gateHighHold
      |=> stat.done && count == $past(count, 4) + COUNT_W'(3))
    else $error("three-cycle pulse measured wrong");
endmodule
`default_nettype wire

// file: shared/gpt_pkg.sv
/*
  Package for the gated pulse width timer: widths, reset values and
  the control/status carriers shared by the timer and its gate stage.
  Assumes a single clock domain and a synchronous active-low reset.
*/
`default_nettype none
package gpt_pkg;
  // Counter geometry and reset values
  localparam int GPT_COUNT_W = 16;
  localparam logic [GPT_COUNT_W-1:0] GPT_COUNT_RST = 16'h0000;
  localparam logic GPT_GATE_IDLE = 1'b1;  // Gate high holds the count
  localparam int GPT_SYNC_STAGES = 2;  // Retiming flops ahead of the gate

  // Control carrier from software (no register bus: plain pins)
  typedef struct packed {
    logic invert;   // output_invert_bit
    logic sync;     // comparator_sync_bit
    logic enable;   // gated_timer on
    logic clear;    // one-cycle pulse: zero the count
    logic load;     // one-cycle pulse: load preset value
  } gpt_ctrl_t;

  // Status carrier to software
  typedef struct packed {
    logic gateLow;   // Timer gate input as seen by the counter
    logic counting;  // Count advanced this cycle
    logic done;      // Sticky: a measurement window has closed
  } gpt_stat_t;

  // Measurement phase
  typedef enum logic [1:0] {GPT_IDLE, GPT_MEASURE, GPT_DONE} gpt_state_t;
endpackage
`default_nettype wire

// file: verification/gpt_comp_model.sv
/*
  Model of the comparator that drives the timer gate, with an optional
  external falling-edge retiming flop. Assumes level comes from the bench.
*/
`default_nettype none
module gpt_comp_model
(
  input wire logic ref_clk,
  input wire logic level,
  input wire logic retime,
  output logic compOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic heldLevel = 1'b1;
  // Falling edge keeps the gate clear of the counting edge
  always_ff @(negedge ref_clk)
  begin
    heldLevel <= level;
  end
  // Raw level only when the timer retimes internally
  assign compOut = retime ? heldLevel : level;
endmodule
`default_nettype wire

// file: verification/gpt_timer_bench.sv
/*
  Self-checking bench for the gated pulse width timer.
  Assumes a 125 MHz ref_clk and the comparator model beside it.
*/
`default_nettype none
module gpt_timer_bench
  import gpt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic level = 1'b1;
  logic retime = 1'b1;
  logic compOut;
  gpt_ctrl_t ctrl = '0;
  logic [15:0] preset = 16'h0000;
  logic [15:0] count;
  gpt_stat_t stat;
  int n_mismatch = 0;
  int n_checks = 0;
  gpt_comp_model gpt_comp_model_inst (.ref_clk(ref_clk), .level(level), .retime(retime),
    .compOut(compOut));
  gpt_timer gpt_timer_inst (.ref_clk(ref_clk), .rstn(rstn), .compOut(compOut), .ctrl(ctrl),
    .preset(preset), .count(count), .stat(stat));
  // Free-running clock
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic close_out();
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] exp);
    n_checks++;
    if (count !== exp)
    begin
      $display("unexpected t=%0t count %h want %h", $time, count, exp);
      n_mismatch++;
    end
  endtask
  // Flags packed as gateLow, counting, done
  task automatic check_stat(input gpt_stat_t exp);
    n_checks++;
    if (stat !== exp)
    begin
      $display("unexpected t=%0t stat %b want %b", $time, stat, exp);
      n_mismatch++;
    end
  endtask
  // Settle idle gate first so a polarity change cannot leak counts
  task automatic pulse(input logic inv, input logic syn, input logic ld, input int w);
    level <= ~inv;
    ctrl <= '{inv, syn, 1'b1, 1'b0, 1'b0};
    repeat (3) @(posedge ref_clk);
    ctrl.clear <= ~ld;
    ctrl.load <= ld;
    @(posedge ref_clk);
    ctrl.clear <= 1'b0;
    ctrl.load <= 1'b0;
    @(posedge ref_clk);
    level <= inv;
    repeat (w) @(posedge ref_clk);
    level <= ~inv;
    // Gate still low at the edge that raises it: both flags up
    @(posedge ref_clk);
    check_stat(3'h6);
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic s_plain();
    retime <= 1'b1;
    pulse(1'b0, 1'b0, 1'b0, 5);
    check(16'h0005);
    check_stat(3'h1);
    repeat (6) @(posedge ref_clk);
    check(16'h0005);
    n_checks++;
    if (stat.done !== 1'b1)
    begin
      $display("unexpected t=%0t done flag low", $time);
      n_mismatch++;
    end
  endtask
  task automatic s_invert();
    pulse(1'b1, 1'b0, 1'b0, 7);
    check(16'h0007);
    check_stat(3'h1);
  endtask
  // Asynchronous comparator, timer retimes it
  task automatic s_sync();
    retime <= 1'b0;
    pulse(1'b0, 1'b1, 1'b0, 3);
    check(16'h0003);
    check_stat(3'h1);
  endtask
  // Reload near the top so the count wraps
  task automatic s_reload();
    preset <= 16'hfffe;
    pulse(1'b0, 1'b1, 1'b1, 3);
    check(16'h0001);
    check_stat(3'h1);
  endtask
  // Clear and load together, then a low gate with the timer off
  task automatic s_refused();
    retime <= 1'b1;
    ctrl <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    @(posedge ref_clk);
    ctrl.clear <= 1'b0;
    ctrl.load <= 1'b0;
    level <= 1'b0;
    repeat (5) @(posedge ref_clk);
    check(16'h0000);
    check_stat(3'h4);
  endtask
  // Main sequence
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    s_plain();
    s_invert();
    s_sync();
    s_reload();
    s_refused();
    close_out();
  end
endmodule
`default_nettype wire
